// File: core/wdg_consts.vh
`ifndef WDG_CONSTS_VH
`define WDG_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDG_OFS_INTERVAL   8'h01
`define WDG_OFS_CONTROL    8'h02
`define WDG_OFS_PINCFG     8'h03
`define WDG_OFS_EDGE       8'h04
`define WDG_OFS_STATUS     8'h06

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WDG_RST_INTERVAL   8'hFF
`define WDG_RST_CONTROL    3'h0
`define WDG_RST_DIR        4'hF
`define WDG_RST_LEVEL      4'h0
`define WDG_RST_EDGESEL    4'h0
`define WDG_RST_FILTER     3'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDG_ON_BIT         0
`define WDG_ACT_HI         2
`define WDG_ACT_LO         1
`define WDG_DIR_HI         3
`define WDG_DIR_LO         0
`define WDG_LVL_HI         7
`define WDG_LVL_LO         4
`define WDG_EDGE_HI        3
`define WDG_EDGE_LO        0
`define WDG_FLT_HI         6
`define WDG_FLT_LO         4

// ----------------------------------------
// Timeout actions
// ----------------------------------------
`define WDG_ACT_FLAG       2'b00
`define WDG_ACT_RESET      2'b01

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDG_TICK_CYC       25'h17D7840
`define WDG_FLT_10MS_CYC   18'h3D090
`define WDG_FLT_5MS_CYC    18'h1E848
`define WDG_FLT_1MS_CYC    18'h061A8
`define WDG_FLT_500US_CYC  18'h030D4

`endif

// File: core/wdg_gpio_core.v
`timescale 1ns/1ps
`include "wdg_consts.vh"

module wdg_gpio_core #(
   parameter [24:0] TICK_CYC  = `WDG_TICK_CYC,
   parameter [17:0] FLT10_CYC = `WDG_FLT_10MS_CYC,
   parameter [17:0] FLT5_CYC  = `WDG_FLT_5MS_CYC,
   parameter [17:0] FLT1_CYC  = `WDG_FLT_1MS_CYC,
   parameter [17:0] FLT05_CYC = `WDG_FLT_500US_CYC
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       reset,
   // Register port from the serial front end
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_write,
   input  wire       reg_read,
   output reg  [7:0] reg_rdata,
   output reg        reg_hit,
   // Device addressed on the bus
   input  wire       bus_addressed,
   // Mask from the interrupt mask register
   input  wire [3:0] interrupt_mask,
   // General-purpose pins
   input  wire [3:0] gpio_in,
   output reg  [3:0] gpio_out,
   output reg  [3:0] gpio_oe_n,
   // Flags and actions
   output reg        watchdog_flag,
   output reg  [3:0] pin_flag,
   output reg        motor_force_off,
   output reg        chip_reset_req
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [7:0]  watchdog_interval;
   reg  [2:0]  watchdog_control;
   reg  [3:0]  pin_dir;
   reg  [3:0]  pin_level;
   reg  [3:0]  pin_edge_sel;
   reg  [2:0]  pin_filter_sel;
   reg  [24:0] tick_cnt;
   reg  [7:0]  wd_count;
   reg  [17:0] filt_limit;
   reg         pins_seeded;
   wire [3:0]  pin_filt;
   wire [3:0]  pin_prev;

   wire        watchdog_on;
   wire [1:0]  timeout_action;
   wire        wr_interval;
   wire        wr_control;
   wire        wr_pincfg;
   wire        wr_edge;
   wire        status_access;
   wire        wd_running;
   wire        wd_reload;
   wire        sec_tick;
   wire        wd_timeout;
   wire        act_reset;
   wire        act_stop;
   wire [3:0]  edge_rise;
   wire [3:0]  edge_fall;
   wire [3:0]  edge_hit;
   wire        next_watchdog_flag;
   wire [3:0]  next_pin_flag;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign watchdog_on    = watchdog_control[`WDG_ON_BIT];
   assign timeout_action =
      watchdog_control[`WDG_ACT_HI:`WDG_ACT_LO];

   assign wr_interval = reg_write && (reg_addr == `WDG_OFS_INTERVAL);
   assign wr_control  = reg_write && (reg_addr == `WDG_OFS_CONTROL);
   assign wr_pincfg   = reg_write && (reg_addr == `WDG_OFS_PINCFG);
   assign wr_edge     = reg_write && (reg_addr == `WDG_OFS_EDGE);
   assign status_access = (reg_write || reg_read) &&
                          (reg_addr == `WDG_OFS_STATUS);

   // ----------------------------------------
   // Watchdog timer
   // ----------------------------------------
   assign wd_running = watchdog_on &&
                       (watchdog_interval != 8'h00);
   assign wd_reload  = bus_addressed || wr_interval ||
                       !wd_running;
   assign sec_tick   = wd_running && (tick_cnt == TICK_CYC - 25'h1);
   assign wd_timeout = sec_tick && !wd_reload &&
                       (wd_count == 8'h01);
   assign act_reset  = wd_timeout &&
                       (timeout_action == `WDG_ACT_RESET);
   assign act_stop   = wd_timeout && timeout_action[1];

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_cnt <= 25'h0000000;
         wd_count <= `WDG_RST_INTERVAL;
      end else if (act_reset) begin
         tick_cnt <= 25'h0000000;
         wd_count <= `WDG_RST_INTERVAL;
      end else if (wd_reload) begin
         tick_cnt <= 25'h0000000;
         wd_count <= wr_interval ? reg_wdata : watchdog_interval;
      end else if (sec_tick) begin
         tick_cnt <= 25'h0000000;
         if (wd_count == 8'h01) begin
            wd_count <= watchdog_interval;
         end else begin
            wd_count <= wd_count - 8'h01;
         end
      end else begin
         tick_cnt <= tick_cnt + 25'h0000001;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         watchdog_interval <= `WDG_RST_INTERVAL;
         watchdog_control  <= `WDG_RST_CONTROL;
         pin_dir           <= `WDG_RST_DIR;
         pin_level         <= `WDG_RST_LEVEL;
         pin_edge_sel      <= `WDG_RST_EDGESEL;
         pin_filter_sel    <= `WDG_RST_FILTER;
      end else if (act_reset) begin
         watchdog_interval <= `WDG_RST_INTERVAL;
         watchdog_control  <= `WDG_RST_CONTROL;
         pin_dir           <= `WDG_RST_DIR;
         pin_level         <= `WDG_RST_LEVEL;
         pin_edge_sel      <= `WDG_RST_EDGESEL;
         pin_filter_sel    <= `WDG_RST_FILTER;
      end else begin
         if (wr_interval) begin
            watchdog_interval <= reg_wdata;
         end
         if (wr_control) begin
            watchdog_control <= reg_wdata[2:0];
         end
         if (wr_pincfg) begin
            pin_dir   <= reg_wdata[`WDG_DIR_HI:`WDG_DIR_LO];
            pin_level <= reg_wdata[`WDG_LVL_HI:`WDG_LVL_LO];
         end
         if (wr_edge) begin
            pin_edge_sel   <= reg_wdata[`WDG_EDGE_HI:`WDG_EDGE_LO];
            pin_filter_sel <= reg_wdata[`WDG_FLT_HI:`WDG_FLT_LO];
         end
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else if (reg_read) begin
         reg_hit <= 1'b1;
         case (reg_addr)
            `WDG_OFS_INTERVAL: reg_rdata <= watchdog_interval;
            `WDG_OFS_CONTROL:  reg_rdata <= {5'h00, watchdog_control};
            `WDG_OFS_PINCFG:   reg_rdata <= {pin_level, pin_dir};
            `WDG_OFS_EDGE:     reg_rdata <= {1'b0, pin_filter_sel,
                                             pin_edge_sel};
            default: begin
               reg_rdata <= 8'h00;
               reg_hit   <= 1'b0;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end
   end

   // ----------------------------------------
   // Input glitch filter for pins 0 and 1
   // ----------------------------------------
   always @* begin
      case (pin_filter_sel)
         3'h0:    filt_limit = 18'h00000;
         3'h1:    filt_limit = FLT05_CYC;
         3'h2:    filt_limit = FLT1_CYC;
         3'h3:    filt_limit = FLT5_CYC;
         default: filt_limit = FLT10_CYC;
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pins_seeded <= 1'b0;
      end else begin
         pins_seeded <= 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         reg [17:0] stable_cnt;
         reg        filt_q;
         reg        prev_q;
         assign pin_filt[gi] = filt_q;
         assign pin_prev[gi] = prev_q;
         always @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               stable_cnt <= 18'h00000;
               filt_q     <= 1'b0;
               prev_q     <= 1'b0;
            end else if (!pins_seeded) begin
               stable_cnt <= 18'h00000;
               filt_q     <= gpio_in[gi];
               prev_q     <= gpio_in[gi];
            end else begin
               prev_q <= filt_q;
               if (gi > 1 || filt_limit == 18'h00000) begin
                  stable_cnt <= 18'h00000;
                  filt_q     <= gpio_in[gi];
               end else if (gpio_in[gi] == filt_q) begin
                  stable_cnt <= 18'h00000;
               end else if (stable_cnt >= filt_limit - 18'h00001) begin
                  stable_cnt <= 18'h00000;
                  filt_q     <= gpio_in[gi];
               end else begin
                  stable_cnt <= stable_cnt + 18'h00001;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Edge detect and flags
   // ----------------------------------------
   assign edge_rise = pin_filt & ~pin_prev;
   assign edge_fall = ~pin_filt & pin_prev;
   assign edge_hit  = ~interrupt_mask & pin_dir &
                      ((pin_edge_sel & edge_fall) |
                       (~pin_edge_sel & edge_rise));

   assign next_pin_flag =
      (pin_flag & ~{4{status_access || act_reset}}) | edge_hit;
   assign next_watchdog_flag =
      (watchdog_flag && !status_access) || wd_timeout;

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         watchdog_flag   <= 1'b0;
         pin_flag        <= 4'h0;
         motor_force_off <= 1'b0;
         chip_reset_req  <= 1'b0;
      end else begin
         watchdog_flag  <= next_watchdog_flag;
         pin_flag       <= next_pin_flag;
         chip_reset_req <= act_reset;
         if (act_stop) begin
            motor_force_off <= 1'b1;
         end else if (!next_watchdog_flag) begin
            motor_force_off <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         gpio_out  <= `WDG_RST_LEVEL;
         gpio_oe_n <= `WDG_RST_DIR;
      end else begin
         gpio_out  <= pin_level;
         gpio_oe_n <= pin_dir;
      end
   end

endmodule

// File: dv/wdg_gpio_props.sv
`timescale 1ns/1ps
module wdg_gpio_props (
   // Clock and reset
   input wire       clk_sys,
   input wire       reset,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_write,
   input wire       reg_read,
   input wire [7:0] reg_rdata,
   input wire       reg_hit,
   // Bus and pins
   input wire       bus_addressed,
   input wire [3:0] interrupt_mask,
   input wire [3:0] gpio_in,
   input wire [3:0] gpio_out,
   input wire [3:0] gpio_oe_n,
   // Flags and actions
   input wire       watchdog_flag,
   input wire [3:0] pin_flag,
   input wire       motor_force_off,
   input wire       chip_reset_req
);
   wire stat_acc = (reg_read || reg_write) && reg_addr == 8'h06;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   read_hit_a: assert property (
      reg_read && reg_addr inside {[8'h01:8'h04]} |=> reg_hit)
      else $error("mapped read gave no hit");
   ctrl_reserved_a: assert property (
      reg_read && reg_addr == 8'h02 |=> reg_rdata[7:3] == 5'h00)
      else $error("control reserved bits not zero");
   mode_reserved_a: assert property (
      reg_read && reg_addr == 8'h04 |=> !reg_rdata[7])
      else $error("edge register bit 7 not zero");
   status_clear_a: assert property (
      stat_acc && interrupt_mask == 4'hF |=> pin_flag == 4'h0)
      else $error("status access left pin flags");
   masked_none_a: assert property (
      interrupt_mask == 4'hF && pin_flag == 4'h0 |=> pin_flag == 4'h0)
      else $error("masked pin raised a flag");
   force_hold_a: assert property (
      motor_force_off && watchdog_flag && !stat_acc |=> motor_force_off)
      else $error("motor force dropped while flag set");
   reset_pulse_a: assert property (
      chip_reset_req |=> !chip_reset_req ##1
      gpio_oe_n == 4'hF && gpio_out == 4'h0)
      else $error("reset request not one cycle or pins kept");
   pin_config_a: assert property (
      reg_write && reg_addr == 8'h03 |-> ##2
      {gpio_out, gpio_oe_n} == $past(reg_wdata, 2))
      else $error("pin config not applied");
   flag_hold_a: assert property (
      watchdog_flag && !stat_acc |=> watchdog_flag)
      else $error("watchdog flag lost without access");
   force_flag_a: assert property (
      motor_force_off |-> watchdog_flag)
      else $error("motor force without watchdog flag");
   reset_flag_a: assert property (
      chip_reset_req |-> watchdog_flag)
      else $error("reset request without watchdog flag");
endmodule

// File: dv/wdg_sensor_model.sv
`timescale 1ns/1ps
module wdg_sensor_model (
   // Pin side of the core
   input  wire [3:0] gpio_out,
   input  wire [3:0] gpio_oe_n,
   // Sensor levels
   input  wire [3:0] sensor_lvl,
   output wire [3:0] gpio_in
);
   // Driven pins show the driver, released pins the sensor
   assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & sensor_lvl);
endmodule

// File: dv/wdg_gpio_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
   num_checks++; \
   if ((a) !== (b)) begin \
      failures++; \
      $display("mismatch t=%0t got %h exp %h", $time, a, b); \
   end \
end
module wdg_gpio_core_tb;
   logic        clk_sys = 0;
   logic        reset = 1;
   logic [7:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0;
   logic        reg_write = 0;
   logic        reg_read = 0;
   logic        bus_addressed = 0;
   logic [3:0]  interrupt_mask = 4'hF;
   logic [3:0]  sensor_lvl = 0;
   wire  [7:0]  reg_rdata;
   wire         reg_hit;
   wire  [3:0]  gpio_in, gpio_out, gpio_oe_n, pin_flag;
   wire         watchdog_flag, motor_force_off, chip_reset_req;
   int          failures = 0;
   int          num_checks = 0;
   int          n_rst = 0;
   logic [23:0] rows [0:5] = '{24'h015A5A, 24'h02F800, 24'h020606,
                               24'h03A5A5, 24'h04FF7F, 24'h040000};
   wdg_gpio_core #(.TICK_CYC(25'd8), .FLT10_CYC(18'd5),
      .FLT5_CYC(18'd4), .FLT1_CYC(18'd3), .FLT05_CYC(18'd2))
   wdg_gpio_core_i (.clk_sys(clk_sys), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .bus_addressed(bus_addressed), .interrupt_mask(interrupt_mask),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .watchdog_flag(watchdog_flag), .pin_flag(pin_flag),
      .motor_force_off(motor_force_off), .chip_reset_req(chip_reset_req));
   wdg_sensor_model wdg_sensor_model_i (.gpio_out(gpio_out),
      .gpio_oe_n(gpio_oe_n), .sensor_lvl(sensor_lvl), .gpio_in(gpio_in));
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (chip_reset_req === 1'b1) n_rst++;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk_sys);
      reg_write = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input h);
      @(negedge clk_sys);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clk_sys);
      reg_read = 1'b0;
      `CHK(reg_rdata, e)
      `CHK(reg_hit, h)
   endtask
   task automatic wait_flag(input int lim);
      for (int k = 0; k < lim && watchdog_flag !== 1'b1; k++)
         @(negedge clk_sys);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      tally_and_finish();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      cyc(4);
      reset = 1'b0;
      rd(8'h01, 8'hFF, 1'b1);
      rd(8'h02, 8'h00, 1'b1);
      rd(8'h03, 8'h0F, 1'b1);
      rd(8'h04, 8'h10, 1'b1);
      rd(8'h05, 8'h00, 1'b0);
      for (int r = 0; r < 6; r++) begin
         wr(rows[r][23:16], rows[r][15:8]);
         rd(rows[r][23:16], rows[r][7:0], 1'b1);
      end
      wr(8'h03, 8'h0F);
      wr(8'h04, 8'h00);
      interrupt_mask = 4'h0;
      sensor_lvl = 4'hF;
      cyc(6);
      `CHK(pin_flag, 4'hF)
      wr(8'h06, 8'h00);
      cyc(1);
      `CHK(pin_flag, 4'h0)
      wr(8'h04, 8'h0F);
      sensor_lvl = 4'h0;
      cyc(6);
      `CHK(pin_flag, 4'hF)
      wr(8'h06, 8'h00);
      sensor_lvl = 4'hF;
      cyc(6);
      `CHK(pin_flag, 4'h0)
      interrupt_mask = 4'hF;
      sensor_lvl = 4'h0;
      cyc(6);
      `CHK(pin_flag, 4'h0)
      wr(8'h04, 8'h40);
      interrupt_mask = 4'h0;
      sensor_lvl = 4'h1;
      cyc(2);
      sensor_lvl = 4'h0;
      cyc(10);
      `CHK(pin_flag, 4'h0)
      sensor_lvl = 4'h1;
      cyc(12);
      `CHK(pin_flag, 4'h1)
      interrupt_mask = 4'hF;
      wr(8'h06, 8'h00);
      wr(8'h01, 8'h02);
      wr(8'h02, 8'h01);
      cyc(10);
      `CHK(watchdog_flag, 1'b0)
      repeat (6) begin
         bus_addressed = 1'b1;
         cyc(1);
         bus_addressed = 1'b0;
         cyc(9);
      end
      `CHK(watchdog_flag, 1'b0)
      wait_flag(30);
      `CHK(watchdog_flag, 1'b1)
      `CHK(motor_force_off, 1'b0)
      `CHK(n_rst, 0)
      for (int m = 0; m < 2; m++) begin
         wr(8'h02, 8'h00);
         wr(8'h06, 8'h00);
         wr(8'h02, 8'h05 + 8'(2 * m));
         wait_flag(40);
         `CHK(watchdog_flag, 1'b1)
         `CHK(motor_force_off, 1'b1)
         wr(8'h06, 8'h00);
         cyc(2);
         `CHK(motor_force_off, 1'b0)
      end
      wr(8'h02, 8'h00);
      wr(8'h06, 8'h00);
      wr(8'h03, 8'h50);
      cyc(1);
      `CHK({gpio_out, gpio_oe_n}, 8'h50)
      wr(8'h02, 8'h03);
      wait_flag(40);
      cyc(3);
      `CHK(n_rst, 1)
      rd(8'h01, 8'hFF, 1'b1);
      rd(8'h02, 8'h00, 1'b1);
      rd(8'h03, 8'h0F, 1'b1);
      rd(8'h04, 8'h10, 1'b1);
      `CHK({gpio_out, gpio_oe_n}, 8'h0F)
      `CHK(watchdog_flag, 1'b1)
      wr(8'h06, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h01);
      cyc(100);
      `CHK(watchdog_flag, 1'b0)
      wr(8'h03, 8'h50);
      wr(8'h01, 8'h02);
      wr(8'h02, 8'h05);
      wait_flag(40);
      `CHK(motor_force_off, 1'b1)
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      cyc(1);
      `CHK({watchdog_flag, motor_force_off}, 2'h0)
      `CHK({gpio_out, gpio_oe_n}, 8'h0F)
      rd(8'h02, 8'h00, 1'b1);
      rd(8'h01, 8'hFF, 1'b1);
      tally_and_finish();
   end
endmodule
bind wdg_gpio_core wdg_gpio_props wdg_gpio_props_i (
   .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .bus_addressed(bus_addressed), .interrupt_mask(interrupt_mask),
   .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
   .watchdog_flag(watchdog_flag), .pin_flag(pin_flag),
   .motor_force_off(motor_force_off), .chip_reset_req(chip_reset_req));
